// ==== rtl/crc_engine_pkg.sv ====
// Constants for the program memory CRC engine.
// Assumes a byte-wide program memory with one-cycle registered read.
package crc_engine_pkg;
  localparam int               ADDR_W        = 13;
  localparam logic [12:0]      USER_LAST     = 13'h1DFF;
  localparam logic [12:0]      MEM_FIRST     = 13'h0000;
  localparam logic [12:0]      MEM_DEPTH     = 13'h1E00;
  localparam logic [7:0]       BLOCK_LOW     = 8'h00;
  localparam logic [7:0]       BLOCK_LAST_LO = 8'hFF;
  localparam logic [31:0]      POLY32        = 32'h04C11DB7;
  localparam logic [15:0]      POLY16        = 16'h1021;
  localparam logic [31:0]      SEED32        = 32'hFFFFFFFF;
  localparam logic [15:0]      SEED16        = 16'h0000;
  localparam logic [31:0]      RESULT_RESET  = 32'h00000000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_FEED = 2'b10
  } crc_state_type;
endpackage

// ==== rtl/prog_mem.sv ====
// Byte-wide program memory model store with registered read data.
// Assumes the same clock as the engine; writes come from the programming path.
`timescale 1ns/1ns
module prog_mem (
  input  wire logic        sys_clk,
  input  wire logic        wr_en,
  input  wire logic [12:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic [12:0] rd_addr,
  output logic      [7:0]  rd_data
);
  logic [7:0] mem [0:8191];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ==== rtl/program_memory_crc_engine.sv ====
// Program memory CRC engine: block CRC-16 and user-memory (0x0000-0x1DFF) CRC-32.
// Assumes the debug interface gives one-cycle write strobes per result byte.
`timescale 1ns/1ns
module program_memory_crc_engine (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        read_lock,
  input  wire logic        write_lock,
  input  wire logic        crc_result_byte0_wr,
  input  wire logic        crc_result_byte1_wr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        mem_wr_en,
  input  wire logic [12:0] mem_wr_addr,
  input  wire logic [7:0]  mem_wr_data,
  output logic             prog_busy_flag,
  output logic [7:0]       debug_address_register,
  output logic [31:0]      crc_result_bytes,
  output logic [15:0]      crc_result_low_pair,
  output logic             crc_done
);
  crc_engine_pkg::crc_state_type state_r, state_nxt;
  logic [12:0] addr_r, addr_nxt;
  logic [12:0] last_r, last_nxt;
  logic        wide_r, wide_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic        done_r, done_nxt;
  logic [7:0]  mem_byte;
  logic [12:0] rd_addr;

  // Lock inputs deliberately unused: verification must work on locked parts
  logic unused_lock;
  assign unused_lock = read_lock | write_lock;

  function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] v;
    v = c ^ {d, 24'h000000};
    for (int i = 0; i < 8; i++) begin
      v = v[31] ? ((v << 1) ^ crc_engine_pkg::POLY32) : (v << 1);
    end
    return v;
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      v = v[15] ? ((v << 1) ^ crc_engine_pkg::POLY16) : (v << 1);
    end
    return v;
  endfunction

  assign rd_addr = addr_r;

  prog_mem u_mem (
    .sys_clk (sys_clk),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_addr (rd_addr),
    .rd_data (mem_byte)
  );

  always_comb begin
    state_nxt = state_r;
    addr_nxt  = addr_r;
    last_nxt  = last_r;
    wide_nxt  = wide_r;
    crc_nxt   = crc_r;
    done_nxt  = 1'b0;
    case (state_r)
      crc_engine_pkg::ST_IDLE: begin
        // Only idle accepts starts, so a write during busy is dropped
        if (crc_result_byte0_wr) begin
          addr_nxt  = {wr_data[4:0], crc_engine_pkg::BLOCK_LOW};
          last_nxt  = {wr_data[4:0], crc_engine_pkg::BLOCK_LAST_LO};
          wide_nxt  = 1'b0;
          crc_nxt   = {16'h0000, crc_engine_pkg::SEED16};
          state_nxt = crc_engine_pkg::ST_READ;
        end else if (crc_result_byte1_wr) begin
          addr_nxt  = crc_engine_pkg::MEM_FIRST;
          last_nxt  = crc_engine_pkg::USER_LAST;
          wide_nxt  = 1'b1;
          crc_nxt   = crc_engine_pkg::SEED32;
          state_nxt = crc_engine_pkg::ST_READ;
        end
      end
      crc_engine_pkg::ST_READ: begin
        state_nxt = crc_engine_pkg::ST_FEED;
      end
      crc_engine_pkg::ST_FEED: begin
        if (wide_r) begin
          crc_nxt = crc32_byte(crc_r, mem_byte);
        end else begin
          crc_nxt = {16'h0000, crc16_byte(crc_r[15:0], mem_byte)};
        end
        if (addr_r == last_r) begin
          state_nxt = crc_engine_pkg::ST_IDLE;
          done_nxt  = 1'b1;
        end else begin
          addr_nxt  = addr_r + 13'h0001;
          state_nxt = crc_engine_pkg::ST_READ;
        end
      end
      default: begin
        state_nxt = crc_engine_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= crc_engine_pkg::ST_IDLE;
      addr_r  <= crc_engine_pkg::MEM_FIRST;
      last_r  <= crc_engine_pkg::MEM_FIRST;
      wide_r  <= 1'b0;
      crc_r   <= crc_engine_pkg::RESULT_RESET;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r  <= addr_nxt;
      last_r  <= last_nxt;
      wide_r  <= wide_nxt;
      crc_r   <= crc_nxt;
      done_r  <= done_nxt;
    end
  end

  assign prog_busy_flag         = (state_r != crc_engine_pkg::ST_IDLE);
  assign debug_address_register = {prog_busy_flag, 7'h00};
  assign crc_result_bytes       = crc_r;
  assign crc_result_low_pair    = crc_r[15:0];
  assign crc_done               = done_r;

  // Checks
  chk_busy_on_start: assert property (@(posedge sys_clk) disable iff (rst)
    (!prog_busy_flag && (crc_result_byte0_wr || crc_result_byte1_wr)) |=> prog_busy_flag)
    else $error("busy not raised after start");
  chk_done_clears_busy: assert property (@(posedge sys_clk) disable iff (rst)
    done_r |-> !prog_busy_flag && $past(prog_busy_flag))
    else $error("done without busy ending");
  chk_block_aligned: assert property (@(posedge sys_clk) disable iff (rst)
    (prog_busy_flag && !wide_r) |-> (last_r[7:0] == 8'hFF && last_r[12:8] == addr_r[12:8]))
    else $error("block not aligned");
  chk_block_start_low: assert property (@(posedge sys_clk) disable iff (rst)
    (!prog_busy_flag && crc_result_byte0_wr) |=> (addr_r[7:0] == 8'h00 && !wide_r))
    else $error("block start low byte not zero");
  chk_wide_start: assert property (@(posedge sys_clk) disable iff (rst)
    (!prog_busy_flag && !crc_result_byte0_wr && crc_result_byte1_wr)
      |=> (addr_r == 13'h0000 && wide_r && last_r == 13'h1DFF))
    else $error("wide CRC bounds wrong");
  chk_user_bound: assert property (@(posedge sys_clk) disable iff (rst)
    (prog_busy_flag && wide_r) |-> (addr_r <= 13'h1DFF))
    else $error("address beyond user memory");
  chk_ascending: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == crc_engine_pkg::ST_FEED && state_nxt == crc_engine_pkg::ST_READ)
      |=> addr_r == $past(addr_r) + 13'h0001)
    else $error("address not ascending");
  chk_busy_ignores: assert property (@(posedge sys_clk) disable iff (rst)
    (prog_busy_flag && crc_result_byte0_wr) |=> $stable(wide_r) && $stable(last_r))
    else $error("start taken while busy");
  chk_low_pair: assert property (@(posedge sys_clk) disable iff (rst)
    (done_r && !wide_r) |-> crc_result_bytes[31:16] == 16'h0000)
    else $error("16-bit result upper bytes not zero");
  chk_block_length: assert property (@(posedge sys_clk) disable iff (rst)
    (!prog_busy_flag && crc_result_byte0_wr) |=> prog_busy_flag [*8])
    else $error("block CRC ended early");
endmodule

// ==== dv/debug_host.sv ====
// Debug host model: starts CRC runs by result-byte writes and polls busy.
// Assumes it shares sys_clk with the engine and drives on the falling edge.
`timescale 1ns/1ns
module debug_host (
  input  wire logic sys_clk,
  input  wire logic prog_busy_flag,
  output logic      crc_result_byte0_wr,
  output logic      crc_result_byte1_wr,
  output logic [7:0] wr_data
);
  initial begin
    crc_result_byte0_wr = 1'b0;
    crc_result_byte1_wr = 1'b0;
    wr_data = 8'h00;
  end
  // Start, prod once with a block start while busy, count busy cycles
  task automatic run(input logic whole, input logic [7:0] d, output int n);
    @(negedge sys_clk);
    crc_result_byte0_wr = !whole;
    crc_result_byte1_wr = whole;
    wr_data = d;
    @(negedge sys_clk);
    crc_result_byte1_wr = 1'b0;
    n = 0;
    for (int k = 0; k < 20000; k++) begin
      if (prog_busy_flag) n++;
      else if (n > 0) break;
      crc_result_byte0_wr = (k == 3);
      wr_data = (k == 3) ? 8'h00 : ~d;
      @(negedge sys_clk);
    end
  endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the program memory CRC engine.
// Assumes memory is filled through the test write port before CRC runs.
`timescale 1ns/1ns
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic read_lock = 1'b0;
  logic write_lock = 1'b0;
  logic mem_wr_en = 1'b0;
  logic [12:0] mem_wr_addr = 13'h0000;
  logic [7:0] mem_wr_data = 8'h00;
  logic b0, b1, busy, done;
  logic [7:0] wd, dar;
  logic [31:0] res;
  logic [15:0] lp;
  int bad_count = 0, compares = 0, cyc = 0, n;
  always #4 sys_clk = ~sys_clk;
  program_memory_crc_engine program_memory_crc_engine_inst (.sys_clk(sys_clk), .rst(rst),
    .read_lock(read_lock), .write_lock(write_lock), .crc_result_byte0_wr(b0),
    .crc_result_byte1_wr(b1), .wr_data(wd), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .prog_busy_flag(busy), .debug_address_register(dar),
    .crc_result_bytes(res), .crc_result_low_pair(lp), .crc_done(done));
  debug_host debug_host_inst (.sys_clk(sys_clk), .prog_busy_flag(busy),
    .crc_result_byte0_wr(b0), .crc_result_byte1_wr(b1), .wr_data(wd));
  function automatic logic [7:0] pat(input int a);
    return a[7:0] ^ {a[12:8], 3'b101};
  endfunction
  // Bitwise reference, MSB first; slow, and shares only the seeds of crc_engine_pkg with the design
  function automatic logic [31:0] crc(input int first, input int last, input logic wide);
    logic [31:0] c;
    c = wide ? crc_engine_pkg::SEED32 : {16'h0000, crc_engine_pkg::SEED16};
    for (int a = first; a <= last; a++) begin
      c ^= wide ? {pat(a), 24'h000000} : {16'h0000, pat(a), 8'h00};
      for (int j = 0; j < 8; j++)
        if (wide) c = c[31] ? (c << 1) ^ 32'h04C11DB7 : c << 1;
        else c = {16'h0000, c[15] ? (c[15:0] << 1) ^ 16'h1021 : c[15:0] << 1};
    end
    return c;
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic reset_values();
    check("busy", 32'h0, {31'h0, busy});
    check("result", 32'h0, res);
  endtask
  task automatic fill();
    for (int a = 0; a < 8192; a++) begin
      @(negedge sys_clk);
      mem_wr_en = 1'b1;
      mem_wr_addr = a[12:0];
      mem_wr_data = pat(a);
    end
    @(negedge sys_clk);
    mem_wr_en = 1'b0;
  endtask
  // Locked part, aligned block; a start while busy must change nothing
  task automatic block_locked(input logic [7:0] page);
    read_lock = 1'b1;
    write_lock = 1'b1;
    debug_host_inst.run(1'b0, page, n);
    check("block busy", 32'd512, n);
    check("done", 32'h1, {31'h0, done});
    check("pair", crc(page * 256, page * 256 + 255, 1'b0), {16'h0, lp});
    check("bytes", crc(page * 256, page * 256 + 255, 1'b0), {16'h0, res[15:0]});
    check("addr reg", 32'h0, {24'h0, dar});
  endtask
  task automatic whole_after_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    debug_host_inst.run(1'b1, 8'h5A, n);
    check("whole busy", 32'd15360, n);
    check("whole done", 32'h1, {31'h0, done});
    check("crc32", crc(0, 32'h1DFF, 1'b1), res);
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    reset_values();
    fill();
    block_locked(8'h02);
    block_locked(8'h1F);
    whole_after_reset();
    end_of_test();
  end
endmodule
